// >>> logic/pp_pkg.sv
package pp_pkg;

  // ==========================================================================
  // Sizes
  localparam int PP_NPINS = 32;
  localparam int PP_HALF  = 16;
  localparam int PP_AW    = 12;

  // ==========================================================================
  // Register indices as printed; the byte address is four times the index.
  localparam logic [7:0]  PP_IDX_MODE_LO = 8'h70;
  localparam logic [7:0]  PP_IDX_DIR_LO  = 8'h72;
  localparam logic [7:0]  PP_IDX_DATA_LO = 8'h74;
  localparam logic [7:0]  PP_IDX_MODE_HI = 8'h76;
  localparam logic [7:0]  PP_IDX_DIR_HI  = 8'h78;
  localparam logic [7:0]  PP_IDX_DATA_HI = 8'h7A;
  localparam logic [11:0] PP_ADDR_MODE_LO = {2'h0, PP_IDX_MODE_LO, 2'h0};
  localparam logic [11:0] PP_ADDR_DIR_LO  = {2'h0, PP_IDX_DIR_LO, 2'h0};
  localparam logic [11:0] PP_ADDR_DATA_LO = {2'h0, PP_IDX_DATA_LO, 2'h0};
  localparam logic [11:0] PP_ADDR_MODE_HI = {2'h0, PP_IDX_MODE_HI, 2'h0};
  localparam logic [11:0] PP_ADDR_DIR_HI  = {2'h0, PP_IDX_DIR_HI, 2'h0};
  localparam logic [11:0] PP_ADDR_DATA_HI = {2'h0, PP_IDX_DATA_HI, 2'h0};

  // ==========================================================================
  // Values after reset
  localparam logic [15:0] PP_MODE_LO_RST = 16'h0000;
  localparam logic [15:0] PP_MODE_HI_RST = 16'h0000;
  localparam logic [15:0] PP_DIR_LO_RST  = 16'hFC0F;
  localparam logic [15:0] PP_DIR_HI_RST  = 16'hFFFF;
  localparam logic [31:0] PP_DATA_RST    = 32'h0000_0000;

  // ==========================================================================
  // Pin 6 pulls down; pins 26 and 29 follow the bus-high strap.
  localparam logic [31:0] PP_PULLDN_MASK  = 32'h0000_0040;
  localparam logic [31:0] PP_STRAP_MASK   = 32'h2400_0000;
  localparam logic [1:0]  PP_STRAP_SETTLE = 2'h2;

  // ==========================================================================
  // Pad controls during reset, decoded from the reset configuration.
  localparam logic [31:0] PP_PULLED_RST = {PP_DIR_HI_RST, PP_DIR_LO_RST} &
                                          ~{PP_MODE_HI_RST, PP_MODE_LO_RST};
  localparam logic [31:0] PP_PULLUP_RST = PP_PULLED_RST & ~PP_PULLDN_MASK;
  localparam logic [31:0] PP_PULLDN_RST = PP_PULLED_RST & PP_PULLDN_MASK;
  localparam logic [31:0] PP_OWNS_RST   = ~({PP_DIR_HI_RST, PP_DIR_LO_RST} |
                                            {PP_MODE_HI_RST, PP_MODE_LO_RST});

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {PP_FN_NORMAL, PP_FN_IN_PULL, PP_FN_OUT, PP_FN_IN_FLOAT} pp_fn_t;
  typedef enum logic [2:0] {PP_SEL_MODE_LO, PP_SEL_DIR_LO, PP_SEL_DATA_LO, PP_SEL_MODE_HI,
                            PP_SEL_DIR_HI, PP_SEL_DATA_HI, PP_SEL_NONE} pp_sel_t;

  // ==========================================================================
  // Decode of one pin's select and direction pair.
  function automatic pp_fn_t pp_fn(input logic m, input logic d);
    pp_fn_t f;
    case ({m, d})
      2'h0:    f = PP_FN_NORMAL;
      2'h1:    f = PP_FN_IN_PULL;
      2'h2:    f = PP_FN_OUT;
      default: f = PP_FN_IN_FLOAT;
    endcase
    return f;
  endfunction

  // Register select from a byte address.
  function automatic pp_sel_t pp_decode(input logic [11:0] a);
    pp_sel_t s;
    if (a == PP_ADDR_MODE_LO)
      s = PP_SEL_MODE_LO;
    else if (a == PP_ADDR_DIR_LO)
      s = PP_SEL_DIR_LO;
    else if (a == PP_ADDR_DATA_LO)
      s = PP_SEL_DATA_LO;
    else if (a == PP_ADDR_MODE_HI)
      s = PP_SEL_MODE_HI;
    else if (a == PP_ADDR_DIR_HI)
      s = PP_SEL_DIR_HI;
    else if (a == PP_ADDR_DATA_HI)
      s = PP_SEL_DATA_HI;
    else
      s = PP_SEL_NONE;
    return s;
  endfunction

  // Byte-lane merge of a 16-bit register write.
  function automatic logic [15:0] pp_merge16(input logic [15:0] old, input logic [15:0] wd,
                                             input logic [1:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0])
      r[7:0] = wd[7:0];
    if (strb[1])
      r[15:8] = wd[15:8];
    return r;
  endfunction

endpackage

// >>> logic/pp_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser; only the second stage leaves the module.
module pp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  logic         pclk,
  input  logic         presetn,
  // Data
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // ==========================================================================
  // Two stages; the first is read by the second and by nothing else.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// >>> logic/pp_port.sv
`timescale 1ns/1ps
//
// How it works
// - Output pins drive the level held in their data register bit.
// - Input pins copy the sampled pin level into their data bit.
// - Select,direction: 00 normal, 01 input pulled, 10 output, 11 input floating.
// - Pins 0-15 use low registers, 16-31 high registers; register bit n is pin n, or pin n+16 in a high register.
// - Low direction register resets to FC0F.
// - High direction register resets to all ones.
// - Both function-select registers reset to zero.
// - Data registers hold no meaningful value until written or sampled.
// - After reset every pin is normal or pulled input.
// - Pin 6 pulls down as a pulled input; other pins pull up.
// - Bus-high strap low at reset puts pins 26 and 29 in normal use.
module pp_port
  import pp_pkg::*;
(
  // Clock and reset
  input  logic                    pclk,
  input  logic                    presetn,
  // APB slave
  input  logic                    psel,
  input  logic                    penable,
  input  logic                    pwrite,
  input  logic [pp_pkg::PP_AW-1:0] paddr,
  input  logic [31:0]             pwdata,
  input  logic [3:0]              pstrb,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Pads
  input  logic [31:0]             pin_in,
  input  logic                    bus_high_strap_n,
  output logic [31:0]             pin_out,
  output logic [31:0]             pin_oe,
  output logic [31:0]             pin_pull_up,
  output logic [31:0]             pin_pull_down,
  // Peripheral side in normal use
  input  logic [31:0]             periph_out,
  input  logic [31:0]             periph_oe,
  output logic [31:0]             periph_in,
  output logic [31:0]             periph_owns
);
  import pp_pkg::*;

  logic [31:0] mode_r;
  logic [31:0] mode_nxt;
  logic [31:0] dir_r;
  logic [31:0] dir_nxt;
  logic [31:0] data_r;
  logic [31:0] data_nxt;
  logic [31:0] wdata_nxt;
  logic [31:0] pin_sync;
  logic        strap_sync;
  logic [1:0]  strap_cnt_r;
  logic        strap_pend_r;
  logic        strap_apply;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] pin_out_r;
  logic [31:0] pin_oe_r;
  logic [31:0] pull_up_r;
  logic [31:0] pull_dn_r;
  logic [31:0] owns_r;
  logic [31:0] pin_out_nxt;
  logic [31:0] pin_oe_nxt;
  logic [31:0] pull_up_nxt;
  logic [31:0] pull_dn_nxt;
  logic [31:0] owns_nxt;
  logic [31:0] in_mask_r;
  logic [31:0] out_mask_r;
  logic [31:0] pull_mask_r;
  logic        xfer_done;
  logic        wr;
  pp_sel_t     sel;
  logic [15:0] rd_val;

  // ==========================================================================
  // Input synchronisers
  // Pads and the strap come from outside the clock domain.
  pp_sync #(
    .W (PP_NPINS + 1)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({bus_high_strap_n, pin_in}),
    .q       ({strap_sync, pin_sync})
  );

  // ==========================================================================
  // APB slave
  // One wait state so that read data and the error flag come from flops.
  assign sel       = pp_decode(paddr);
  assign xfer_done = psel & penable & pready_r;
  assign wr        = xfer_done & pwrite & (sel != PP_SEL_NONE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready_r <= 1'b0;
    else
      pready_r <= psel & penable & ~pready_r;
  end

  // Read mux; unmapped addresses read zero and answer with an error.
  always_comb
  begin
    case (sel)
      PP_SEL_MODE_LO: rd_val = mode_r[15:0];
      PP_SEL_DIR_LO:  rd_val = dir_r[15:0];
      PP_SEL_DATA_LO: rd_val = data_r[15:0];
      PP_SEL_MODE_HI: rd_val = mode_r[31:16];
      PP_SEL_DIR_HI:  rd_val = dir_r[31:16];
      PP_SEL_DATA_HI: rd_val = data_r[31:16];
      default:        rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else if (psel & penable & ~pready_r)
    begin
      prdata_r  <= {16'h0000, rd_val};
      pslverr_r <= (sel == PP_SEL_NONE);
    end
    else
      pslverr_r <= 1'b0;
  end

  // ==========================================================================
  // Strap capture
  // The synchroniser needs two edges after release before its output is real.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_cnt_r  <= 2'h0;
      strap_pend_r <= 1'b1;
    end
    else if (strap_pend_r)
    begin
      if (strap_cnt_r == PP_STRAP_SETTLE)
        strap_pend_r <= 1'b0;
      else
        strap_cnt_r <= strap_cnt_r + 2'h1;
    end
  end

  assign strap_apply = strap_pend_r & (strap_cnt_r == PP_STRAP_SETTLE) & ~strap_sync;

  // ==========================================================================
  // Current pin decode
  always_comb
  begin
    in_mask_r   = '0;
    out_mask_r  = '0;
    pull_mask_r = '0;
    for (int i = 0; i < PP_NPINS; i++)
    begin
      case (pp_fn(mode_r[i], dir_r[i]))
        PP_FN_IN_PULL:
        begin
          in_mask_r[i]   = 1'b1;
          pull_mask_r[i] = 1'b1;
        end
        PP_FN_IN_FLOAT: in_mask_r[i]  = 1'b1;
        PP_FN_OUT:      out_mask_r[i] = 1'b1;
        default:        ;
      endcase
    end
  end

  // ==========================================================================
  // Register next values
  // Low register writes land in pins 0-15, high ones in pins 16-31.
  always_comb
  begin
    mode_nxt  = mode_r;
    dir_nxt   = dir_r;
    wdata_nxt = data_r;
    if (wr)
    begin
      if (sel == PP_SEL_MODE_LO)
        mode_nxt[15:0] = pp_merge16(mode_r[15:0], pwdata[15:0], pstrb[1:0]);
      else if (sel == PP_SEL_DIR_LO)
        dir_nxt[15:0] = pp_merge16(dir_r[15:0], pwdata[15:0], pstrb[1:0]);
      else if (sel == PP_SEL_DATA_LO)
        wdata_nxt[15:0] = pp_merge16(data_r[15:0], pwdata[15:0], pstrb[1:0]);
      else if (sel == PP_SEL_MODE_HI)
        mode_nxt[31:16] = pp_merge16(mode_r[31:16], pwdata[15:0], pstrb[1:0]);
      else if (sel == PP_SEL_DIR_HI)
        dir_nxt[31:16] = pp_merge16(dir_r[31:16], pwdata[15:0], pstrb[1:0]);
      else
        wdata_nxt[31:16] = pp_merge16(data_r[31:16], pwdata[15:0], pstrb[1:0]);
    end
    if (strap_apply)
    begin
      mode_nxt = mode_nxt & ~PP_STRAP_MASK;
      dir_nxt  = dir_nxt & ~PP_STRAP_MASK;
    end
    // Input pins take the synchronised level; a write to them is overwritten.
    data_nxt = (wdata_nxt & ~in_mask_r) | (pin_sync & in_mask_r);
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r <= {PP_MODE_HI_RST, PP_MODE_LO_RST};
      dir_r  <= {PP_DIR_HI_RST, PP_DIR_LO_RST};
    end
    else
    begin
      mode_r <= mode_nxt;
      dir_r  <= dir_nxt;
    end
  end

  // Data is cleared only for a known start; software must not rely on it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      data_r <= PP_DATA_RST;
    else
      data_r <= data_nxt;
  end

  // ==========================================================================
  // Pad controls
  // Built from next values so a write shows on the pads at the same edge.
  always_comb
  begin
    pin_out_nxt = '0;
    pin_oe_nxt  = '0;
    pull_up_nxt = '0;
    pull_dn_nxt = '0;
    owns_nxt    = '0;
    for (int i = 0; i < PP_NPINS; i++)
    begin
      case (pp_fn(mode_nxt[i], dir_nxt[i]))
        PP_FN_NORMAL:
        begin
          owns_nxt[i]    = 1'b1;
          pin_out_nxt[i] = periph_out[i];
          pin_oe_nxt[i]  = periph_oe[i];
        end
        PP_FN_IN_PULL:
        begin
          pull_dn_nxt[i] = PP_PULLDN_MASK[i];
          pull_up_nxt[i] = ~PP_PULLDN_MASK[i];
        end
        PP_FN_OUT:
        begin
          pin_out_nxt[i] = data_nxt[i];
          pin_oe_nxt[i]  = 1'b1;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out_r <= '0;
      pin_oe_r  <= '0;
      // Pads show the reset configuration's pulls at once, not one edge late.
      pull_up_r <= PP_PULLUP_RST;
      pull_dn_r <= PP_PULLDN_RST;
      owns_r    <= PP_OWNS_RST;
    end
    else
    begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r  <= pin_oe_nxt;
      pull_up_r <= pull_up_nxt;
      pull_dn_r <= pull_dn_nxt;
      owns_r    <= owns_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = pslverr_r;
  assign pin_out       = pin_out_r;
  assign pin_oe        = pin_oe_r;
  assign pin_pull_up   = pull_up_r;
  assign pin_pull_down = pull_dn_r;
  assign periph_in     = pin_sync;
  assign periph_owns   = owns_r;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_OUT_DRIVE: assert property (
    (((pin_out_r ^ data_r) & out_mask_r) == '0) && ((pin_oe_r & out_mask_r) == out_mask_r))
    else $error("output pin not driving its data bit");

  AST_IN_SAMPLE: assert property (
    1'b1 |=> (((data_r ^ $past(pin_sync)) & $past(in_mask_r)) == '0))
    else $error("input pin level not captured");

  AST_DECODE: assert property (
    ((pull_up_r | pull_dn_r) == pull_mask_r) && ((pin_oe_r & in_mask_r) == '0))
    else $error("pin pair decoded wrongly");

  AST_HI_MAP: assert property (
    wr && sel == PP_SEL_MODE_HI && pstrb[1:0] == 2'h3 && !strap_apply
    |=> mode_r[31:16] == $past(pwdata[15:0]) && $stable(mode_r[15:0]))
    else $error("high select write misplaced");

  AST_RST_DIR_LO: assert property (
    $rose(presetn) |-> dir_r[15:0] == PP_DIR_LO_RST)
    else $error("low direction reset value wrong");

  AST_RST_DIR_HI: assert property (
    $rose(presetn) |-> dir_r[31:16] == PP_DIR_HI_RST)
    else $error("high direction reset value wrong");

  AST_RST_MODE: assert property (
    $rose(presetn) |-> mode_r == '0 && pin_oe_r == '0)
    else $error("select registers not cleared by reset");

  AST_RST_SAFE: assert property (
    strap_pend_r |-> (out_mask_r == '0) && ((in_mask_r & ~pull_mask_r) == '0))
    else $error("pin neither normal nor pulled input after reset");

  AST_PULLDN: assert property (
    ((pull_dn_r & ~PP_PULLDN_MASK) == '0) && !pull_up_r[6])
    else $error("pull direction wrong");

  AST_STRAP: assert property (
    strap_apply |=> ((dir_r | mode_r) & PP_STRAP_MASK) == '0 && !strap_pend_r)
    else $error("strap did not restore normal use");

  AST_WR_PIN: assert property (
    wr && sel == PP_SEL_DATA_LO && pstrb[1:0] == 2'h3
    |=> ((pin_out_r[15:0] ^ $past(pwdata[15:0])) & out_mask_r[15:0]) == 16'h0000)
    else $error("data write not on pins next edge");

  AST_APB_WAIT: assert property (
    psel && penable && !pready_r |=> pready_r ##1 !pready_r)
    else $error("slave answer not after one wait state");

  AST_APB_ERR: assert property (
    pslverr_r |-> pready_r)
    else $error("error flag outside the answer");

  COV_WRITE: cover property (wr ##1 (out_mask_r != '0));
  COV_READ: cover property (xfer_done && !pwrite && sel == PP_SEL_DATA_HI);
  COV_UNMAPPED: cover property (xfer_done && pslverr_r);
  COV_STRAP: cover property (strap_apply);

endmodule

// >>> test/pp_board.sv
`timescale 1ns/1ps
// ============================================================================
// Board model for the pads: device drive first, then an external source,
// then a pull resistor, and a pattern that flips every cycle on a bare pad.
module pp_board (
  // Clock
  input  logic        pclk,
  // Device pad side
  input  logic [31:0] pin_out,
  input  logic [31:0] pin_oe,
  input  logic [31:0] pin_pull_up,
  input  logic [31:0] pin_pull_down,
  // External source commanded by the bench
  input  logic [31:0] ext_drv,
  input  logic [31:0] ext_val,
  // Pad level seen by the device
  output logic [31:0] pin_in
);
  logic        tog_r = 1'b0;
  logic [31:0] bare;

  // A floating pad must not hold its last value, so it shows a moving pattern.
  always @(posedge pclk)
    tog_r <= ~tog_r;

  assign bare = {16{2'h1}} ^ {32{tog_r}};

  // A pull-down resolves to zero and a pull-up to one on undriven pads.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val) |
                  (~pin_oe & ~ext_drv & (pin_pull_up | (~pin_pull_down & bare)));
endmodule

// >>> test/programmable_io_port_tb.sv
`timescale 1ns/1ps
// ============================================================================
// Self-checking bench: a register table loop, then hand-written pin cases.
module programmable_io_port_tb;
  import pp_pkg::*;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wd;
    logic [3:0]  st;
    logic [31:0] rd;
    logic        err;
  } pp_row_t;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_high_strap_n, er;
  logic [11:0] paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down, rd;
  logic [31:0] periph_out, periph_oe, periph_in, periph_owns, ext_drv, ext_val;
  pp_row_t     rows [6];
  int          fails, checks, cyc;

  pp_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .bus_high_strap_n(bus_high_strap_n),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pin_pull_up),
    .pin_pull_down(pin_pull_down), .periph_out(periph_out), .periph_oe(periph_oe),
    .periph_in(periph_in), .periph_owns(periph_owns));

  pp_board board (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pin_pull_up),
    .pin_pull_down(pin_pull_down), .ext_drv(ext_drv), .ext_val(ext_val), .pin_in(pin_in));

  // 50 MHz clock.
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // The whole run needs well under a thousand cycles; a hang ends at the ceiling.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      stop_test();
    end
  end

  task automatic stop_test;
    if (fails == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] wd,
                     input logic [3:0] st);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, 4'hF);
  endtask

  task automatic rdr(input logic [11:0] a);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask

  // The strap is held through release so its sample at the third edge sees it.
  task automatic do_reset(input logic strap);
    @(posedge pclk);
    presetn          <= 1'b0;
    bus_high_strap_n <= strap;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    @(negedge pclk);
  endtask

  initial
  begin
    {psel, penable, pwrite, presetn} = 4'h0;
    bus_high_strap_n = 1'b1;
    paddr = 12'h000;
    pstrb = 4'h0;
    {pwdata, periph_out, periph_oe, ext_drv, ext_val} = {5{32'h0000_0000}};
    // Upper write bits and unused lanes must not reach a 16-bit register.
    rows = '{'{PP_ADDR_MODE_LO, 32'hDEAD_A5A5, 4'hF, 32'h0000_A5A5, 1'b0},
             '{PP_ADDR_DIR_LO,  32'h0000_1234, 4'hF, 32'h0000_1234, 1'b0},
             '{PP_ADDR_MODE_HI, 32'h0000_FFFF, 4'h1, 32'h0000_00FF, 1'b0},
             '{PP_ADDR_DIR_HI,  32'h0000_5A00, 4'h2, 32'h0000_5AFF, 1'b0},
             '{12'h1C4,         32'h0000_FFFF, 4'hF, 32'h0000_0000, 1'b1},
             '{12'h1F0,         32'h0000_FFFF, 4'hF, 32'h0000_0000, 1'b1}};
    do_reset(1'b1);
    // Configuration after reset, strap high.
    check("owns", periph_owns, 32'h0000_03F0);
    check("pull up", pin_pull_up, 32'hFFFF_FC0F);
    check("pull down", pin_pull_down, 32'h0000_0000);
    rdr(PP_ADDR_MODE_LO);
    check("mode lo rst", rd, 32'h0000_0000);
    rdr(PP_ADDR_MODE_HI);
    check("mode hi rst", rd, 32'h0000_0000);
    rdr(PP_ADDR_DIR_LO);
    check("dir lo rst", rd, 32'h0000_FC0F);
    rdr(PP_ADDR_DIR_HI);
    check("dir hi rst", rd, 32'h0000_FFFF);
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].addr, rows[i].wd, rows[i].st);
      check("write err", {31'h0, er}, {31'h0, rows[i].err});
      rdr(rows[i].addr);
      check("read data", rd, rows[i].rd);
      check("read err", {31'h0, er}, {31'h0, rows[i].err});
    end
    // Every pin driven; the pins change at the completing edge of the write.
    wr(PP_ADDR_MODE_LO, 32'h0000_FFFF);
    wr(PP_ADDR_MODE_HI, 32'h0000_FFFF);
    wr(PP_ADDR_DIR_LO, 32'h0000_0000);
    wr(PP_ADDR_DIR_HI, 32'h0000_0000);
    wr(PP_ADDR_DATA_LO, 32'h0000_5A3C);
    wr(PP_ADDR_DATA_HI, 32'h0000_C3A5);
    @(negedge pclk);
    check("out level", pin_out, 32'hC3A5_5A3C);
    check("out enable", pin_oe, 32'hFFFF_FFFF);
    check("out pulls", pin_pull_up | pin_pull_down | periph_owns, 32'h0);
    rdr(PP_ADDR_DATA_LO);
    check("out data", rd, 32'h0000_5A3C);
    // Floating inputs copy the pads through the synchroniser.
    wr(PP_ADDR_DIR_LO, 32'h0000_FFFF);
    wr(PP_ADDR_DIR_HI, 32'h0000_FFFF);
    ext_drv <= 32'hFFFF_FFFF;
    ext_val <= 32'h1357_9BDF;
    repeat (5) @(posedge pclk);
    rdr(PP_ADDR_DATA_LO);
    check("in lo", rd, 32'h0000_9BDF);
    rdr(PP_ADDR_DATA_HI);
    check("in hi", rd, 32'h0000_1357);
    check("float pulls", pin_pull_up | pin_pull_down | pin_oe, 32'h0);
    // Pulled inputs with nothing else on the pads; pin 6 pulls down.
    wr(PP_ADDR_MODE_LO, 32'h0000_0000);
    wr(PP_ADDR_MODE_HI, 32'h0000_0000);
    ext_drv <= 32'h0000_0000;
    repeat (5) @(posedge pclk);
    check("pull dn", pin_pull_down, 32'h0000_0040);
    check("pull up", pin_pull_up, 32'hFFFF_FFBF);
    rdr(PP_ADDR_DATA_LO);
    check("pulled lo", rd, 32'h0000_FFBF);
    // Normal use hands the pads to the peripheral side.
    wr(PP_ADDR_DIR_LO, 32'h0000_0000);
    wr(PP_ADDR_DIR_HI, 32'h0000_0000);
    periph_out <= 32'h0F0F_F0F0;
    periph_oe  <= 32'hFFFF_FFFF;
    repeat (5) @(posedge pclk);
    @(negedge pclk);
    check("owns all", periph_owns, 32'hFFFF_FFFF);
    check("periph out", pin_out, 32'h0F0F_F0F0);
    check("periph in", periph_in, 32'h0F0F_F0F0);
    @(posedge pclk);
    periph_oe <= 32'h0000_0000;
    // Open drain on pin 0: data held at zero, direction follows the level wanted.
    wr(PP_ADDR_MODE_LO, 32'h0000_0001);
    wr(PP_ADDR_DATA_LO, 32'h0000_0000);
    @(negedge pclk);
    check("od low", {30'h0, pin_oe[0], pin_out[0]}, 32'h0000_0002);
    wr(PP_ADDR_DIR_LO, 32'h0000_0001);
    @(negedge pclk);
    check("od off", {31'h0, pin_oe[0]}, 32'h0);
    // A second reset with the strap low returns pins 26 and 29 to normal use.
    do_reset(1'b0);
    check("strap owns", periph_owns, 32'h2400_03F0);
    rdr(PP_ADDR_DIR_HI);
    check("strap dir", rd, 32'h0000_DBFF);
    rdr(PP_ADDR_DIR_LO);
    check("dir lo again", rd, 32'h0000_FC0F);
    rdr(PP_ADDR_MODE_HI);
    check("strap mode", rd, 32'h0000_0000);
    stop_test();
  end
endmodule
